/* File: include/scs_map.svh */
// Register offsets, field positions, reset values and timing counts of the serial controller submode block.
// Included by bare name; holds definitions only.
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// Device register select codes
`define SCS_REG_HOLD        2'h0
`define SCS_REG_STAT        2'h1
`define SCS_REG_MODE        2'h2
`define SCS_REG_CMD         2'h3

// Mode register fields
`define SCS_MR_ASYNC        0
`define SCS_MR_PAR_EN       4
`define SCS_MR_PAR_EVEN     5
`define SCS_MR_TRANSP       6
`define SCS_MR_SYNC_CNT     7
`define SCS_MODE_RST        8'h00

// Command register fields
`define SCS_CR_TX_EN        0
`define SCS_CR_DTR          1
`define SCS_CR_RX_EN        2
`define SCS_CR_RST_ERR      4
`define SCS_CR_RTS          5
`define SCS_CR_OP_LO        6
`define SCS_CR_OP_HI        7
`define SCS_CMD_RST         8'h00

// Status register fields
`define SCS_SR_THR_EMPTY    0
`define SCS_SR_RHR_FULL     1
`define SCS_SR_EMPTY_CHG    2
`define SCS_SR_PAR_ESC      3
`define SCS_SR_OVERRUN      4
`define SCS_SR_FRAME_SYNC   5
`define SCS_SR_DCD_LOW      6
`define SCS_SR_DSR_LOW      7

// Special characters
`define SCS_FIRST_SYNC      8'h16
`define SCS_SECOND_SYNC     8'h17
`define SCS_LINK_ESCAPE     8'h10

// Baud divider: one bit time in pclk cycles
`define SCS_BAUD_DIV        16'h0010
`define SCS_BAUD_HALF       16'h0008

// Host side timing
`define SCS_CLK_MHZ         200
`define SCS_CE_WIDTH_NS     250
`define SCS_CE_REC_NS       600
`define SCS_CE_WIDTH_CYC    ((`SCS_CE_WIDTH_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_CE_REC_CYC      ((`SCS_CE_REC_NS * `SCS_CLK_MHZ + 999) / 1000)

// Host APB registers and access word fields
`define SCS_APB_ACC         32'h0000_0000
`define SCS_APB_RES         32'h0000_0004
`define SCS_ACC_ADDR_LSB    0
`define SCS_ACC_READ        8
`define SCS_ACC_DATA_LSB    16
`define SCS_RES_HOLDOFF     8

`endif

/* File: include/scs_pkg.sv */
// Types shared by both ends of the serial controller submode block.
// No constants here; those live in scs_map.svh.
package scs_pkg;

   typedef enum logic [1:0] {
      SCS_OP_NORMAL = 2'h0,
      SCS_OP_SUBMODE = 2'h1,
      SCS_OP_LOCAL = 2'h2,
      SCS_OP_REMOTE = 2'h3
   } scs_op_t;

   typedef enum logic [3:0] {
      SCS_H_IDLE = 4'h1,
      SCS_H_SETUP = 4'h2,
      SCS_H_ACTIVE = 4'h4,
      SCS_H_DONE = 4'h8
   } scs_hstate_t;

endpackage

/* File: include/scs_bus_if.sv */
// Byte-wide register bus between the host interface end and the device end.
// The shared data wire is resolved here from the two output enables (low = driving).
`timescale 1ns/10ps
`default_nettype none

interface scs_bus_if;
   logic       ce_n;
   logic       rw;
   logic [1:0] reg_sel;
   logic [7:0] dq_host;
   logic       dq_host_oe_n;
   logic [7:0] dq_dev;
   logic       dq_dev_oe_n;
   logic [7:0] dq;

   // Wire level; a floating bus reads as all ones
   assign dq = !dq_dev_oe_n ? dq_dev : (!dq_host_oe_n ? dq_host : 8'hff);

   modport dev (input ce_n, input rw, input reg_sel, input dq, output dq_dev, output dq_dev_oe_n);
   modport host (output ce_n, output rw, output reg_sel, output dq_host, output dq_host_oe_n, input dq);
endinterface

`default_nettype wire

/* File: verilog/scs_host.sv */
// Host end: APB slave that turns software orders into chip-enable cycles on the byte bus.
// Assumes one pclk domain and a device that takes an access when chip enable falls.
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"

module scs_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   scs_bus_if.host          bus
);

   scs_pkg::scs_hstate_t state_q;
   logic [7:0] cnt_q;
   logic [7:0] holdoff_q;
   logic       rw_q;
   logic [1:0] sel_q;
   logic [7:0] wdata_q;
   logic [7:0] result_q;
   logic       ce_n_q;
   logic       acc_hit;
   logic       res_hit;

   assign acc_hit = psel && penable && pwrite && (paddr == `SCS_APB_ACC);
   assign res_hit = psel && !pwrite && (paddr == `SCS_APB_RES);

   // Access sequencer; address is set a cycle before chip enable falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= scs_pkg::SCS_H_IDLE;
         cnt_q <= 8'h00;
         ce_n_q <= 1'b1;
         rw_q <= 1'b0;
         sel_q <= 2'h0;
         wdata_q <= 8'h00;
      end else begin
         unique case (state_q)
            scs_pkg::SCS_H_IDLE: begin
               // A held-off order waits here with pready low
               if (acc_hit && holdoff_q == 8'h00) begin
                  rw_q <= pwdata[`SCS_ACC_READ];
                  sel_q <= pwdata[`SCS_ACC_ADDR_LSB+2 -: 2]; // Host A2:A1 onto select
                  wdata_q <= pwdata[`SCS_ACC_DATA_LSB +: 8];
                  state_q <= scs_pkg::SCS_H_SETUP;
               end
            end
            scs_pkg::SCS_H_SETUP: begin
               ce_n_q <= 1'b0; // Delayed enable gives the read its setup time
               cnt_q <= 8'(`SCS_CE_WIDTH_CYC);
               state_q <= scs_pkg::SCS_H_ACTIVE;
            end
            scs_pkg::SCS_H_ACTIVE: begin
               if (cnt_q == 8'h01) begin
                  ce_n_q <= 1'b1;
                  state_q <= scs_pkg::SCS_H_DONE;
               end
               cnt_q <= cnt_q - 8'h01;
            end
            scs_pkg::SCS_H_DONE: begin
               state_q <= scs_pkg::SCS_H_IDLE;
            end
         endcase
      end
   end

   // Read data sampled as chip enable rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q <= 8'h00;
      end else if (state_q == scs_pkg::SCS_H_ACTIVE && cnt_q == 8'h01 && rw_q) begin
         result_q <= bus.dq;
      end
   end

   // Recovery timer starts when chip enable rises; blocks the next access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         holdoff_q <= 8'h00;
      end else if (state_q == scs_pkg::SCS_H_ACTIVE && cnt_q == 8'h01) begin
         holdoff_q <= 8'(`SCS_CE_REC_CYC);
      end else if (holdoff_q != 8'h00) begin
         holdoff_q <= holdoff_q - 8'h01;
      end
   end

   assign bus.ce_n = ce_n_q;
   assign bus.rw = rw_q;
   assign bus.reg_sel = sel_q;
   assign bus.dq_host = wdata_q;
   // Drive the byte only for a write while the cycle is open
   assign bus.dq_host_oe_n = !(!rw_q && (state_q == scs_pkg::SCS_H_SETUP || state_q == scs_pkg::SCS_H_ACTIVE));

   // Acknowledge to software on the edge after the cycle ends; hold-off suppresses it
   always_comb begin
      pready = 1'b1;
      if (psel && penable && pwrite && paddr == `SCS_APB_ACC) begin
         pready = (state_q == scs_pkg::SCS_H_DONE);
      end
   end

   assign pslverr = psel && penable && (paddr != `SCS_APB_ACC) && (paddr != `SCS_APB_RES);
   assign prdata = res_hit ? {23'h0, (holdoff_q != 8'h00), result_q} : 32'h0000_0000;

endmodule

`default_nettype wire

/* File: verilog/scs_device.sv */
// Device end: register file, serial transmitter and receiver, echo, stripping and loopback submodes.
// Assumes a host that opens each access by pulling chip enable low, one pclk domain, synchronous pins.
// Summary of operation
// - Status byte: tx empty up to DSR low.
// - Async submode echoes received data to line.
// - Echo needs receiver on; host transmit writes ignored.
// - Break echoes once, line high until start.
// - Echo: rx clock, ready high, change only.
// - Single sync stripping drops first sync chars.
// - Double sync drops first, second after first.
// - Transparent drops escape, following sync; escape pairs.
// - Escape and sync flags ignore stripping.
// - Local loop: tx into rx, tx clock.
// - Local loop: DTR to DCD, RTS to CTS.
// - Local loop holds txd, DTR and RTS outputs high, ignores inputs.
// - Local loop: software sets enables; rx enable ignored.
// - Remote loop retransmits received chars, rx clock.
// - Remote loop: no host data, errors still set.
// - Remote loop: three outputs high, tx enable ignored.
// - Host delays enable, acknowledges next edge.
// - Host holds off re-enable during recovery.
// - Hold-off starts at enable release, long enough.
// - Host A2:A1 drive register select.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"

module scs_device (
   input  wire logic pclk,
   input  wire logic presetn,
   scs_bus_if.dev    bus,
   input  wire logic rxd,
   output logic      txd,
   input  wire logic cts_n,
   input  wire logic dcd_n,
   input  wire logic dsr_n,
   output logic      dtr_n,
   output logic      rts_n,
   output logic      transmit_ready_out_n,
   output logic      receive_ready_out_n,
   output logic      empty_or_change_out_n
);

   logic [7:0]  mode_q, cmd_q, thr_q, rhr_q, rdata_q;
   logic        thr_full_q, rhr_full_q, ce_prev_q;
   logic        par_esc_q, ovr_q, fsync_q, chg_q, dcd_prev_q, dsr_prev_q;
   logic [15:0] tx_div_q, rx_div_q;
   logic [7:0]  rx_sh_q;
   logic [3:0]  rx_cnt_q, tx_cnt_q;
   logic        rx_busy_q, rx_arm_q, mark_q, par_bit_q, brk_hold_q, prev_first_sync_char_q, prev_esc_q;
   logic [10:0] tx_sh_q;
   logic        tx_busy_q, txd_q;
   scs_pkg::scs_op_t op;
   logic async, transp, single, par_en, echo, strip, lloop, rloop, loop_tx;
   logic acc, wr, rd, rst_err, stat_rd, hold_rd;
   logic tx_en, rx_en, cts_eff, dcd_eff, dsr_eff, line;
   logic tx_tick, rx_tick, tx_tick_eff, rx_tick_eff, start_ok;
   logic rx_done, fe, pe, is_first_sync_char, is_second_sync_char, is_esc, syn_det, esc_det, strip_hit, deliver, brk;
   logic tx_load, tx_empty;
   logic [7:0] rx_char, tx_byte, status;
   logic [10:0] frame;

   // Mode decode; op field 00 selects none of the submodes
   assign op = scs_pkg::scs_op_t'({cmd_q[`SCS_CR_OP_HI], cmd_q[`SCS_CR_OP_LO]});
   assign async = mode_q[`SCS_MR_ASYNC];
   assign transp = mode_q[`SCS_MR_TRANSP];
   assign single = mode_q[`SCS_MR_SYNC_CNT];
   assign par_en = mode_q[`SCS_MR_PAR_EN] && async;
   assign echo = (op == scs_pkg::SCS_OP_SUBMODE) && async;
   assign strip = (op == scs_pkg::SCS_OP_SUBMODE) && !async;
   assign lloop = (op == scs_pkg::SCS_OP_LOCAL);
   assign rloop = (op == scs_pkg::SCS_OP_REMOTE);
   assign loop_tx = echo || rloop;

   // Effective enables and modem inputs; loops rewire them internally
   assign tx_en = loop_tx ? 1'b1 : cmd_q[`SCS_CR_TX_EN];
   assign rx_en = lloop ? 1'b1 : cmd_q[`SCS_CR_RX_EN];
   assign cts_eff = lloop ? !cmd_q[`SCS_CR_RTS] : cts_n;
   assign dcd_eff = lloop ? !cmd_q[`SCS_CR_DTR] : dcd_n;
   assign dsr_eff = lloop ? 1'b1 : dsr_n;
   assign line = lloop ? txd_q : rxd;

   // Host access is taken once per chip-enable fall
   assign acc = !bus.ce_n && ce_prev_q;
   assign wr = acc && !bus.rw;
   assign rd = acc && bus.rw;
   assign rst_err = wr && bus.reg_sel == `SCS_REG_CMD && bus.dq[`SCS_CR_RST_ERR];
   assign stat_rd = rd && bus.reg_sel == `SCS_REG_STAT;
   assign hold_rd = rd && bus.reg_sel == `SCS_REG_HOLD;

   // Baud dividers; receive divider re-phases on a start edge so samples land mid-bit
   assign tx_tick = (tx_div_q == 16'h0000);
   assign rx_tick = (rx_div_q == 16'h0000);
   assign tx_tick_eff = loop_tx ? rx_tick : tx_tick;
   assign rx_tick_eff = lloop ? tx_tick : rx_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div_q <= 16'h0000;
         rx_div_q <= 16'h0000;
         rx_arm_q <= 1'b0;
      end else begin
         tx_div_q <= tx_tick ? `SCS_BAUD_DIV - 16'h0001 : tx_div_q - 16'h0001;
         if (async && !lloop && !rx_busy_q && !rx_arm_q && mark_q && !line) begin
            rx_div_q <= `SCS_BAUD_HALF;
            rx_arm_q <= 1'b1;
         end else begin
            rx_div_q <= rx_tick ? `SCS_BAUD_DIV - 16'h0001 : rx_div_q - 16'h0001;
            if (rx_tick) rx_arm_q <= 1'b0;
         end
      end
   end

   // Receiver: async frames need a mark before a start is valid
   assign start_ok = rx_tick_eff && !rx_busy_q && !line && mark_q;
   assign rx_done = rx_en && rx_tick_eff && (async ? (rx_busy_q && rx_cnt_q == (par_en ? 4'h9 : 4'h8))
                                                   : (rx_cnt_q == 4'h7));
   assign rx_char = async ? rx_sh_q : {line, rx_sh_q[7:1]};
   assign fe = async && !line;
   assign pe = par_en && (par_bit_q != (^rx_sh_q ^ !mode_q[`SCS_MR_PAR_EVEN]));
   assign brk = fe && rx_sh_q == 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sh_q <= 8'h00;
         rx_cnt_q <= 4'h0;
         rx_busy_q <= 1'b0;
         par_bit_q <= 1'b0;
         mark_q <= 1'b0;
      end else if (!rx_en) begin
         rx_cnt_q <= 4'h0;
         rx_busy_q <= 1'b0;
      end else if (rx_tick_eff) begin
         if (!async) begin
            rx_sh_q <= {line, rx_sh_q[7:1]};
            rx_cnt_q <= (rx_cnt_q == 4'h7) ? 4'h0 : rx_cnt_q + 4'h1;
         end else if (!rx_busy_q) begin
            if (line) mark_q <= 1'b1;
            rx_busy_q <= start_ok;
            rx_cnt_q <= 4'h0;
         end else if (rx_cnt_q < 4'h8) begin
            rx_sh_q <= {line, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
         end else if (!rx_done) begin
            par_bit_q <= line;
            rx_cnt_q <= rx_cnt_q + 4'h1;
         end else begin
            rx_busy_q <= 1'b0;
            mark_q <= line; // A framing error must see a mark again
         end
      end
   end

   // Sync character classes and detectors, independent of stripping
   assign is_first_sync_char = rx_char == `SCS_FIRST_SYNC;
   assign is_second_sync_char = rx_char == `SCS_SECOND_SYNC;
   assign is_esc = rx_char == `SCS_LINK_ESCAPE;
   assign syn_det = transp ? (is_first_sync_char && prev_esc_q) : (single ? is_first_sync_char : (is_second_sync_char && prev_first_sync_char_q));
   assign esc_det = transp && is_esc && !prev_esc_q;
   // Stripping decision per framing
   assign strip_hit = strip && (transp ? ((is_esc && !prev_esc_q) || (is_first_sync_char && prev_esc_q))
                                       : (is_first_sync_char || (!single && is_second_sync_char && prev_first_sync_char_q)));
   assign deliver = rx_done && !strip_hit && !rloop;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_first_sync_char_q <= 1'b0;
         prev_esc_q <= 1'b0;
      end else if (!rx_en || async) begin
         prev_first_sync_char_q <= 1'b0;
         prev_esc_q <= 1'b0;
      end else if (rx_done) begin
         prev_first_sync_char_q <= is_first_sync_char;
         prev_esc_q <= is_esc && !prev_esc_q; // Second escape of a pair is data
      end
   end

   // Receive holding register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rhr_q <= 8'h00;
         rhr_full_q <= 1'b0;
      end else begin
         if (hold_rd) rhr_full_q <= 1'b0;
         if (deliver) begin
            rhr_q <= rx_char;
            rhr_full_q <= 1'b1;
         end
      end
   end

   // Error and change flags; a set in the same cycle as its clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_esc_q <= 1'b0;
         ovr_q <= 1'b0;
         fsync_q <= 1'b0;
         chg_q <= 1'b0;
         dcd_prev_q <= 1'b1;
         dsr_prev_q <= 1'b1;
      end else begin
         dcd_prev_q <= dcd_eff;
         dsr_prev_q <= dsr_eff;
         if (rst_err) par_esc_q <= 1'b0;
         if (rst_err) ovr_q <= 1'b0;
         if (!rx_en || (rst_err && async) || (stat_rd && !async)) fsync_q <= 1'b0;
         if (stat_rd) chg_q <= 1'b0;
         if (rx_done && (async ? pe : esc_det)) par_esc_q <= 1'b1;
         if (rx_done && (async ? fe : syn_det)) fsync_q <= 1'b1;
         if (rx_done && !strip_hit && (rloop ? thr_full_q : rhr_full_q && !hold_rd)) ovr_q <= 1'b1;
         if (dcd_eff != dcd_prev_q || dsr_eff != dsr_prev_q) chg_q <= 1'b1;
      end
   end

   // Transmitter; sync idles with the first sync character as fill
   assign tx_byte = thr_full_q ? thr_q : `SCS_FIRST_SYNC;
   assign tx_load = tx_tick_eff && (!tx_busy_q || tx_cnt_q == 4'h0) && tx_en && !cts_eff
                    && (thr_full_q || !async);
   assign frame = par_en ? {1'b1, (^tx_byte ^ !mode_q[`SCS_MR_PAR_EVEN]), tx_byte, 1'b0}
                         : {2'b11, tx_byte, 1'b0};
   assign tx_empty = !tx_busy_q && !thr_full_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sh_q <= 11'h7ff;
         tx_cnt_q <= 4'h0;
         tx_busy_q <= 1'b0;
         txd_q <= 1'b1;
      end else if (tx_load) begin
         txd_q <= async ? frame[0] : tx_byte[0];
         tx_sh_q <= async ? {1'b1, frame[10:1]} : {4'hf, tx_byte[7:1]};
         tx_cnt_q <= async ? (par_en ? 4'ha : 4'h9) : 4'h7;
         tx_busy_q <= 1'b1;
      end else if (tx_tick_eff && tx_busy_q) begin
         if (tx_cnt_q == 4'h0) begin
            tx_busy_q <= 1'b0;
            txd_q <= 1'b1;
         end else begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
         end
      end
   end

   // Transmit holding register; echo and remote loop feed it from the receiver, host writes then ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_q <= 8'h00;
         thr_full_q <= 1'b0;
      end else begin
         if (tx_load) thr_full_q <= 1'b0;
         if (loop_tx && rx_done && !brk_hold_q) begin
            thr_q <= rx_char;
            thr_full_q <= 1'b1;
         end else if (wr && bus.reg_sel == `SCS_REG_HOLD && !loop_tx) begin
            thr_q <= bus.dq;
            thr_full_q <= 1'b1;
         end
      end
   end

   // Break in echo: the first break character is still loaded and sent; later ones are not loaded,
   // so the transmitter idles high until a valid start clears the hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_hold_q <= 1'b0;
      end else if (!echo || (start_ok && rx_en)) begin
         brk_hold_q <= 1'b0;
      end else if (rx_done && brk) begin
         brk_hold_q <= 1'b1;
      end
   end

   // Host register writes and read data capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `SCS_MODE_RST;
         cmd_q <= `SCS_CMD_RST;
         rdata_q <= 8'h00;
         ce_prev_q <= 1'b1;
      end else begin
         ce_prev_q <= bus.ce_n;
         if (wr && bus.reg_sel == `SCS_REG_MODE) mode_q <= bus.dq;
         if (wr && bus.reg_sel == `SCS_REG_CMD) cmd_q <= {bus.dq[7:5], 1'b0, bus.dq[3:0]};
         if (rd) begin
            unique case (bus.reg_sel)
               `SCS_REG_HOLD: rdata_q <= rhr_q;
               `SCS_REG_STAT: rdata_q <= status;
               `SCS_REG_MODE: rdata_q <= mode_q;
               `SCS_REG_CMD: rdata_q <= cmd_q;
            endcase
         end
      end
   end

   // Status byte, bit 0 upward echo shows change only on bit 2
   assign status = {!dsr_eff, !dcd_eff, fsync_q, ovr_q, par_esc_q,
                    chg_q || (tx_empty && !echo), rhr_full_q, !thr_full_q};

   // Pin outputs, low active; remote loop forces all three high, echo only the transmit ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_ready_out_n <= 1'b1;
         receive_ready_out_n <= 1'b1;
         empty_or_change_out_n <= 1'b1;
      end else begin
         transmit_ready_out_n <= loop_tx || thr_full_q;
         receive_ready_out_n <= rloop || !rhr_full_q;
         empty_or_change_out_n <= rloop || !status[`SCS_SR_EMPTY_CHG];
      end
   end

   assign txd = lloop || txd_q;
   assign dtr_n = lloop || !cmd_q[`SCS_CR_DTR];
   assign rts_n = lloop || !cmd_q[`SCS_CR_RTS];
   assign bus.dq_dev = rdata_q;
   assign bus.dq_dev_oe_n = !(!bus.ce_n && bus.rw && !ce_prev_q);

endmodule

`default_nettype wire

/* File: verification/scs_bus_sva.sv */
// Checker for the byte bus joining the host and device ends.
// Sees only interface signals; the bench instantiates it beside the interface.
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"
module scs_bus_sva (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       ce_n,
   input wire logic       rw,
   input wire logic [1:0] reg_sel,
   input wire logic [7:0] dq_host,
   input wire logic       dq_host_oe_n,
   input wire logic       dq_dev_oe_n
);
   localparam int WID = `SCS_CE_WIDTH_CYC;
   localparam int REC = `SCS_CE_REC_CYC;
   logic [7:0] run_q;
   // Cycles since chip enable changed; saturates so a long idle never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) run_q <= 8'hff;
      else if ($changed(ce_n)) run_q <= 8'h00;
      else if (run_q != 8'hff) run_q <= run_q + 8'h01;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence take_s; $fell(ce_n); endsequence
   sequence drive_s; !dq_dev_oe_n [*8]; endsequence
   ce_width_a: assert property ($rose(ce_n) |-> run_q >= WID - 1)
      else $error("enable pulse short");
   ce_recover_a: assert property (take_s |-> run_q >= REC - 1)
      else $error("enable recovery short");
   sel_setup_a: assert property (take_s |-> $stable(reg_sel) && $stable(rw))
      else $error("select moved at enable");
   sel_hold_a: assert property (!ce_n && !$fell(ce_n) |-> $stable(reg_sel) && $stable(rw))
      else $error("select moved in access");
   read_answer_a: assert property (take_s ##0 rw |=> drive_s)
      else $error("read data not driven");
   dev_float_a: assert property (ce_n |-> dq_dev_oe_n)
      else $error("device drives unselected");
   wr_data_a: assert property (!ce_n && !rw |-> !dq_host_oe_n && $stable(dq_host))
      else $error("write data unstable");
   one_driver_a: assert property (!dq_host_oe_n |-> dq_dev_oe_n)
      else $error("bus contention");
endmodule
`default_nettype wire

/* File: verification/test_serial_controller_submodes.sv */
// Bench: host and device ends joined by the byte bus, driven over APB and serial pins.
// Assumes the APB map and serial bit timing of scs_map.svh.
`timescale 1ns/10ps
`default_nettype none
`include "scs_map.svh"
module test_serial_controller_submodes;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        rxd, txd, cts_n, dcd_n, dsr_n, dtr_n, rts_n, trdy_n, rrdy_n, emp_n;
   logic [31:0] paddr, pwdata, prdata, rnd;
   logic [15:0] notes[$];
   logic [15:0] nt;
   logic [7:0]  v;
   int          failures, check_count;
   scs_bus_if bus ();
   scs_host i_scs_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
                        .pslverr, .bus(bus));
   scs_device i_scs_device (.pclk, .presetn, .bus(bus), .rxd, .txd, .cts_n, .dcd_n, .dsr_n, .dtr_n, .rts_n,
      .transmit_ready_out_n(trdy_n), .receive_ready_out_n(rrdy_n), .empty_or_change_out_n(emp_n));
   scs_bus_sva i_scs_bus_sva (.pclk, .presetn, .ce_n(bus.ce_n), .rw(bus.rw), .reg_sel(bus.reg_sel),
      .dq_host(bus.dq_host), .dq_host_oe_n(bus.dq_host_oe_n), .dq_dev_oe_n(bus.dq_dev_oe_n));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One APB transfer; the wait has no bound here, the watchdog cuts a hang
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Odd byte address: bits 2:1 select the device register
   task automatic acc(input logic [1:0] r, input logic rd, input logic [7:0] b);
      apb(`SCS_APB_ACC, 1'b1, {8'h00, b, 7'h00, rd, 5'h00, r, 1'b1});
   endtask
   task automatic rd(input logic [1:0] r, input logic [7:0] e, input logic [7:0] m);
      acc(r, 1'b1, 8'h00);
      notes.push_back({m, e & m});
      apb(`SCS_APB_RES, 1'b0, 32'h0);
   endtask
   task automatic send(input logic [7:0] b);
      rxd <= 1'b0;
      repeat (16) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         rxd <= (i == 8) ? 1'b1 : b[i];
         repeat (16) @(posedge pclk);
      end
   endtask
   // Bounded hunt for a start bit, then sample mid-bit
   task automatic cap(output logic [7:0] c);
      int i;
      i = 0;
      while (txd !== 1'b0 && i < 3000) begin
         @(posedge pclk);
         i++;
      end
      repeat (8) @(posedge pclk);
      for (int k = 0; k < 8; k++) begin
         repeat (16) @(posedge pclk);
         c[k] = txd;
      end
   endtask
   // Read results are matched against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && paddr == `SCS_APB_RES && notes.size() > 0) begin
         nt = notes.pop_front();
         chk("host read", nt[7:0], prdata[7:0] & nt[15:8]);
      end
   end
   initial begin
      repeat (60000) @(posedge pclk);
      failures++;
      summarize();
   end
   initial begin
      rnd = $urandom(69401);
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {rxd, cts_n, dcd_n, dsr_n} = 4'hf;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rnd = $urandom;
      dcd_n <= rnd[0];
      dsr_n <= rnd[1];
      rd(2'h1, {~rnd[1], ~rnd[0], 6'h00}, 8'hc2);
      wr_rd: begin
         rnd = $urandom;
         acc(2'h2, 1'b0, rnd[7:0] & 8'hf1);
         rd(2'h2, rnd[7:0] & 8'hf1, 8'hff);
         acc(2'h3, 1'b0, rnd[15:8] & 8'h2f);
         rd(2'h3, rnd[15:8] & 8'h2f, 8'hff);
      end
      apb(32'h0000_0010, 1'b0, 32'h0);
      chk("slave error", 8'h01, {7'h00, err});
      $display("registers done");
      rnd = $urandom;
      acc(2'h2, 1'b0, 8'h01);
      cts_n <= 1'b0;
      acc(2'h3, 1'b0, 8'h07);
      send(rnd[7:0]);
      chk("quiet line", 8'h01, {7'h00, txd});
      rd(2'h0, rnd[7:0], 8'hff);
      fork acc(2'h0, 1'b0, rnd[15:8]); cap(v); join
      chk("sent char", rnd[15:8], v);
      $display("normal done");
      acc(2'h3, 1'b0, 8'h44);
      acc(2'h0, 1'b0, ~rnd[23:16]);
      fork send(rnd[23:16]); cap(v); join
      chk("echo char", rnd[23:16], v);
      chk("ready pin", 8'h01, {7'h00, trdy_n});
      rd(2'h0, rnd[23:16], 8'hff);
      // A long low line is one break character; it must be echoed once as all zeros
      fork begin rxd <= 1'b0; repeat (200) @(posedge pclk); rxd <= 1'b1; end cap(v); join
      chk("break echo", 8'h00, v);
      rd(2'h0, 8'h00, 8'hff);
      $display("echo done");
      acc(2'h3, 1'b0, 8'hc4);
      fork send(rnd[31:24]); cap(v); join
      chk("loop char", rnd[31:24], v);
      chk("ready pins", 8'h07, {5'h00, trdy_n, rrdy_n, emp_n});
      rd(2'h1, 8'h00, 8'h02);
      $display("remote done");
      cts_n <= 1'b1;
      dcd_n <= 1'b1;
      acc(2'h3, 1'b0, 8'ha3);
      acc(2'h0, 1'b0, 8'h3c);
      chk("loop pins", 8'h07, {5'h00, dtr_n, rts_n, txd});
      // Let the looped frame finish before status is sampled; its end depends on the baud phase
      repeat (200) @(posedge pclk);
      rd(2'h1, 8'h42, 8'h42);
      rd(2'h0, 8'h3c, 8'hff);
      $display("local done");
      summarize();
   end
endmodule
`default_nettype wire
